// >>> rtl/dss_defs.svh
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DSS_OFF_SYNC_CTRL   8'h00
`define DSS_OFF_DIV_CTRL    8'h04
`define DSS_OFF_SYNC_SEL    8'h08
`define DSS_OFF_IRQ_STATUS  8'h0c
`define DSS_OFF_IRQ_MASK    8'h10
`define DSS_OFF_STATE       8'h14

// ****************************************
// Field positions
// ****************************************
`define DSS_BIT_IN_SYNC_EN  5
`define DSS_BIT_OUT_SYNC_EN 4
`define DSS_BIT_DIV_SYNC_EN 1
`define DSS_BIT_SRC_STROBE  1
`define DSS_EVT_COLLISION   0
`define DSS_EVT_BUS_LOST    1
`define DSS_EVT_CONV_LOST   2
`define DSS_EVT_SYNC_SEEN   3

// ****************************************
// Reset values and counts
// ****************************************
`define DSS_RST_SYNC_CTRL   8'h00
`define DSS_RST_DIV_CTRL    8'h00
`define DSS_RST_SYNC_SEL    8'h00
`define DSS_RST_MASK        4'h0
`define DSS_FIFO_OFFSET     4
`define DSS_LOSS_CYCLES     8'h40

`endif

// >>> rtl/dss_pkg.sv
package dss_pkg;

  // Synchronisation settings taken from the registers
  typedef struct packed {
    logic inSyncEn;
    logic outSyncEn;
    logic divSyncEn;
    logic srcStrobe;
  } dss_sync_cfg_t;

  // Sticky events, same layout as status and mask
  typedef struct packed {
    logic syncSeen;
    logic convLost;
    logic busLost;
    logic collision;
  } dss_events_t;

endpackage

// >>> rtl/dss_sync_core.sv
`timescale 1ns/100ps
// What this block does
// - Input-pointer enable bit 5 makes frame marker reset the FIFO input pointer.
// - Output-pointer enable bit 4 lets the FIFO output pointer be resynced.
// - Select bit 1 picks frame marker or strobe for output pointer and divider.
// - Divider enable bit 1 lets the selected source resync the clock divider.
`include "dss_defs.svh"
module dss_sync_core
  import dss_pkg::*;
#(
  parameter int         DATA_W      = 16,
  parameter int         PTR_W       = 3,
  parameter logic [7:0] LOSS_CYCLES = `DSS_LOSS_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              transmitGate,
  input  wire logic              frameMarker,
  input  wire logic              syncStrobe,
  input  wire logic              busClock,
  input  wire logic              conversionClock,
  input  wire logic [DATA_W-1:0] sampleIn,
  input  wire logic              sampleInValid,
  output logic      [DATA_W-1:0] sampleOut,
  output logic                   sampleOutValid,
  output logic                   irq
);

  localparam int DEPTH = 1 << PTR_W;

  // ****************************************
  // Helper functions
  // ****************************************
  // Watchdog step: clear on an edge, else count up and saturate
  function automatic logic [7:0] lossNext(input logic [7:0] cnt, input logic edgeSeen);
    lossNext = edgeSeen ? 8'h00 : ((cnt == LOSS_CYCLES) ? cnt : cnt + 8'h01);
  endfunction

  // Rising edge of a synchronised pin
  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [4:0]        pinSync1_reg;
  logic [4:0]        pinSync2_reg;
  logic [4:0]        pinPrev_reg;
  logic [7:0]        syncCtrl_reg;
  logic [7:0]        divCtrl_reg;
  logic [7:0]        syncSel_reg;
  dss_events_t       status_reg;
  dss_events_t       status_next;
  dss_events_t       mask_reg;
  logic              ack_reg;
  logic [31:0]       rdData_reg;
  logic [7:0]        busLoss_reg;
  logic [7:0]        convLoss_reg;
  logic [PTR_W:0]    wrPtr_reg;
  logic [PTR_W:0]    wrPtr_next;
  logic [PTR_W:0]    rdPtr_reg;
  logic [PTR_W:0]    rdPtr_next;
  logic              divCount_reg;
  logic [DATA_W-1:0] fifoMem [DEPTH];
  logic [DATA_W-1:0] sampleOut_reg;
  logic              sampleOutValid_reg;
  logic              irq_reg;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Order: gate, frame, strobe, bus clock, conversion clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1_reg <= 5'h00;
      pinSync2_reg <= 5'h00;
      pinPrev_reg  <= 5'h00;
    end else begin
      pinSync1_reg <= {transmitGate, frameMarker, syncStrobe, busClock, conversionClock};
      pinSync2_reg <= pinSync1_reg;
      pinPrev_reg  <= pinSync2_reg;
    end
  end

  wire gateOn     = pinSync2_reg[4];
  wire frameEdge  = rise(pinSync2_reg[3], pinPrev_reg[3]);
  wire strobeEdge = rise(pinSync2_reg[2], pinPrev_reg[2]);
  wire busEdge    = pinSync2_reg[1] ^ pinPrev_reg[1];
  wire convEdge   = pinSync2_reg[0] ^ pinPrev_reg[0];

  // ****************************************
  // Sync configuration and sources
  // ****************************************
  dss_sync_cfg_t cfg;
  assign cfg.inSyncEn  = syncCtrl_reg[`DSS_BIT_IN_SYNC_EN];
  assign cfg.outSyncEn = syncCtrl_reg[`DSS_BIT_OUT_SYNC_EN];
  assign cfg.divSyncEn = divCtrl_reg[`DSS_BIT_DIV_SYNC_EN];
  assign cfg.srcStrobe = syncSel_reg[`DSS_BIT_SRC_STROBE];

  // Selected source for output pointer and divider
  wire outSrcEdge  = cfg.srcStrobe ? strobeEdge : frameEdge;
  wire inPtrSync   = cfg.inSyncEn & frameEdge;
  wire outPtrSync  = cfg.outSyncEn & outSrcEdge;
  wire divSync     = cfg.divSyncEn & outSrcEdge;

  // ****************************************
  // FIFO and divider datapath
  // ****************************************
  wire [PTR_W:0] level    = wrPtr_reg - rdPtr_reg;
  wire           fifoFull = (level == (PTR_W + 1)'(DEPTH));
  wire           fifoEmpty = (level == '0);
  wire           readTick = divCount_reg & gateOn;
  wire           doWrite  = sampleInValid & ~fifoFull;
  wire           doRead   = readTick & ~fifoEmpty;
  wire           collide  = (sampleInValid & fifoFull) | (readTick & fifoEmpty);

  // Pointer updates, sync overrides normal stepping
  assign wrPtr_next = inPtrSync ? '0 : (doWrite ? wrPtr_reg + 1'b1 : wrPtr_reg);
  assign rdPtr_next = outPtrSync ? ('0 - (PTR_W + 1)'(`DSS_FIFO_OFFSET)) :
                      (doRead ? rdPtr_reg + 1'b1 : rdPtr_reg);

  // Pointers and divider phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg    <= '0;
      rdPtr_reg    <= '0;
      divCount_reg <= 1'b0;
    end else begin
      wrPtr_reg    <= wrPtr_next;
      rdPtr_reg    <= rdPtr_next;
      divCount_reg <= divSync ? 1'b0 : ~divCount_reg;
    end
  end

  // Sample storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      fifoMem[wrPtr_reg[PTR_W-1:0]] <= sampleIn;
    end
  end

  // Output stage: zero and invalid while the gate is low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sampleOut_reg      <= '0;
      sampleOutValid_reg <= 1'b0;
    end else begin
      sampleOut_reg      <= doRead ? fifoMem[rdPtr_reg[PTR_W-1:0]] : '0;
      sampleOutValid_reg <= doRead;
    end
  end

  // ****************************************
  // Clock loss watchdogs
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busLoss_reg  <= 8'h00;
      convLoss_reg <= 8'h00;
    end else begin
      busLoss_reg  <= lossNext(busLoss_reg, busEdge);
      convLoss_reg <= lossNext(convLoss_reg, convEdge);
    end
  end

  // Loss events fire once, on the cycle a watchdog saturates
  dss_events_t events;
  assign events.collision = collide;
  assign events.busLost   = (busLoss_reg == LOSS_CYCLES - 8'h01) & ~busEdge;
  assign events.convLost  = (convLoss_reg == LOSS_CYCLES - 8'h01) & ~convEdge;
  assign events.syncSeen  = inPtrSync | outPtrSync | divSync;

  // ****************************************
  // Wishbone slave decode
  // ****************************************
  wire busReq   = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wrLow    = busReq & wb_we_i & wb_sel_i[0];
  wire rdReq    = busReq & ~wb_we_i;
  wire hitCtrl  = (wb_adr_i == `DSS_OFF_SYNC_CTRL);
  wire hitDiv   = (wb_adr_i == `DSS_OFF_DIV_CTRL);
  wire hitSel   = (wb_adr_i == `DSS_OFF_SYNC_SEL);
  wire hitStat  = (wb_adr_i == `DSS_OFF_IRQ_STATUS);
  wire hitMask  = (wb_adr_i == `DSS_OFF_IRQ_MASK);
  wire hitState = (wb_adr_i == `DSS_OFF_STATE);

  // Read selection, unmapped offsets read zero
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitCtrl) begin
      rdMux = {24'h000000, syncCtrl_reg};
    end else if (hitDiv) begin
      rdMux = {24'h000000, divCtrl_reg};
    end else if (hitSel) begin
      rdMux = {24'h000000, syncSel_reg};
    end else if (hitStat) begin
      rdMux = {28'h0000000, status_reg};
    end else if (hitMask) begin
      rdMux = {28'h0000000, mask_reg};
    end else if (hitState) begin
      rdMux = {20'h00000, 3'(rdPtr_reg), 1'b0, 3'(wrPtr_reg), 1'b0,
               gateOn, divCount_reg, fifoEmpty, fifoFull};
    end
  end

  // Read clears status, a new event in the same cycle wins
  assign status_next = (rdReq & hitStat) ? events : (status_reg | events);

  // Register file and handshake
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncCtrl_reg <= `DSS_RST_SYNC_CTRL;
      divCtrl_reg  <= `DSS_RST_DIV_CTRL;
      syncSel_reg  <= `DSS_RST_SYNC_SEL;
      mask_reg     <= `DSS_RST_MASK;
      status_reg   <= '0;
      ack_reg      <= 1'b0;
      rdData_reg   <= 32'h0000_0000;
      irq_reg      <= 1'b0;
    end else begin
      if (wrLow && hitCtrl) begin
        syncCtrl_reg <= wb_dat_i[7:0];
      end
      if (wrLow && hitDiv) begin
        divCtrl_reg <= wb_dat_i[7:0];
      end
      if (wrLow && hitSel) begin
        syncSel_reg <= wb_dat_i[7:0];
      end
      if (wrLow && hitMask) begin
        mask_reg <= wb_dat_i[3:0];
      end
      status_reg <= status_next;
      ack_reg    <= busReq;
      rdData_reg <= rdReq ? rdMux : 32'h0000_0000;
      irq_reg    <= |(status_next & mask_reg);
    end
  end

  assign wb_ack_o       = ack_reg;
  assign wb_dat_o       = rdData_reg;
  assign sampleOut      = sampleOut_reg;
  assign sampleOutValid = sampleOutValid_reg;
  assign irq            = irq_reg;

endmodule

// >>> verification/dss_sync_core_chk.sv
`timescale 1ns/100ps
module dss_sync_core_chk #(
  parameter int DATA_W = 16
) (
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              transmitGate,
  input wire logic [DATA_W-1:0] sampleOut,
  input wire logic              sampleOutValid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Request decode for the bus checks
  wire busReq  = wb_cyc_i && wb_stb_i;
  wire rdGap   = !wb_we_i && wb_adr_i > 8'h14;
  wire rdState = !wb_we_i && wb_adr_i == 8'h14;
  property p_gateOff; !transmitGate [*4] |=> !sampleOutValid && sampleOut == '0; endproperty
  a_gateOff: assert property (p_gateOff) else $error("sample left with gate low");
  property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
  property p_ackNext; busReq && !wb_ack_o |=> wb_ack_o; endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack missing");
  property p_noReq; !busReq |=> !wb_ack_o; endproperty
  a_noReq: assert property (p_noReq) else $error("ack without request");
  property p_datIdle; !wb_ack_o |-> wb_dat_o == '0; endproperty
  a_datIdle: assert property (p_datIdle) else $error("read data outside ack");
  property p_wrZero; wb_ack_o && $past(wb_we_i) |-> wb_dat_o == '0; endproperty
  a_wrZero: assert property (p_wrZero) else $error("data on write ack");
  property p_gap; wb_ack_o && $past(rdGap) |-> wb_dat_o == '0; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read not zero");
  property p_state;
    wb_ack_o && $past(rdState) |-> wb_dat_o[31:12] == '0 && !wb_dat_o[8] && !wb_dat_o[4];
  endproperty
  a_state: assert property (p_state) else $error("state spare bits set");
  property p_validGap; sampleOutValid |=> !sampleOutValid; endproperty
  a_validGap: assert property (p_validGap) else $error("reads closer than divider");
  c_read: cover property (wb_ack_o && !$past(wb_we_i));
  c_valid: cover property (sampleOutValid);
  c_gate: cover property ($rose(transmitGate));
endmodule

bind dss_sync_core dss_sync_core_chk #(.DATA_W(DATA_W)) u_chk (.*);

// >>> verification/dss_ctrl_model.sv
`timescale 1ns/100ps
module dss_ctrl_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic clkRun,
  input  wire logic frameReq,
  input  wire logic strobeReq,
  output logic      busClock,
  output logic      conversionClock,
  output logic      frameMarker,
  output logic      syncStrobe
);
  // Clocks toggle while running and stand still when lost; all idle low in reset
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busClock        <= 1'b0;
      conversionClock <= 1'b0;
      frameMarker     <= 1'b0;
      syncStrobe      <= 1'b0;
    end else begin
      busClock        <= busClock ^ clkRun;
      conversionClock <= conversionClock ^ clkRun;
      frameMarker     <= frameReq;
      syncStrobe      <= strobeReq;
    end
  end
endmodule

// >>> verification/dss_sync_core_tb_top.sv
`timescale 1ns/100ps
module dss_sync_core_tb_top;
  logic        core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic        transmitGate, frameMarker, syncStrobe, busClock, conversionClock;
  logic        sampleInValid, sampleOutValid, clkRun, frameReq, strobeReq;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdVal;
  logic [15:0] sampleIn, sampleOut;
  int          errors = 0, comparisons = 0, cycles = 0;

  dss_sync_core #(.LOSS_CYCLES(8'h08)) DUT (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .wb_cyc_i        (wb_cyc_i),
    .wb_stb_i        (wb_stb_i),
    .wb_we_i         (wb_we_i),
    .wb_adr_i        (wb_adr_i),
    .wb_sel_i        (wb_sel_i),
    .wb_dat_i        (wb_dat_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .transmitGate    (transmitGate),
    .frameMarker     (frameMarker),
    .syncStrobe      (syncStrobe),
    .busClock        (busClock),
    .conversionClock (conversionClock),
    .sampleIn        (sampleIn),
    .sampleInValid   (sampleInValid),
    .sampleOut       (sampleOut),
    .sampleOutValid  (sampleOutValid),
    .irq             (irq)
  );
  dss_ctrl_model u_ctrl (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .clkRun          (clkRun),
    .frameReq        (frameReq),
    .strobeReq       (strobeReq),
    .busClock        (busClock),
    .conversionClock (conversionClock),
    .frameMarker     (frameMarker),
    .syncStrobe      (syncStrobe)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One classic bus cycle, held until ack
  task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rdVal = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pulse(input logic strobe);
    frameReq  <= !strobe;
    strobeReq <= strobe;
    ticks(4);
    frameReq  <= 1'b0;
    strobeReq <= 1'b0;
    ticks(6);
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      sampleInValid <= 1'b1;
      sampleIn      <= 16'h1000 + 16'(i);
      @(posedge core_clk);
    end
    sampleInValid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic watch(input int n, output int s);
    s = 0;
    repeat (n) begin
      @(posedge core_clk);
      s += int'(sampleOutValid === 1'b1);
    end
  endtask

  task automatic t_regs;
    logic [7:0] adrs [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
    foreach (adrs[i]) begin
      wbx(1'b0, adrs[i], 32'h0);
      chk("reset value", 32'h0, rdVal);
      wbx(1'b1, adrs[i], 32'hffff_ffa5);
      wbx(1'b0, adrs[i], 32'h0);
      chk("readback", (adrs[i] == 8'h10) ? 32'h5 : 32'ha5, rdVal);
    end
    wb_sel_i <= 4'h0;
    wbx(1'b1, 8'h00, 32'h0);
    wb_sel_i <= 4'h1;
    wbx(1'b1, 8'h18, 32'hff);
    wbx(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h0, rdVal);
    wbx(1'b0, 8'h00, 32'h0);
    chk("sel ignored", 32'ha5, rdVal);
    foreach (adrs[i]) wbx(1'b1, adrs[i], 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_sync;
    wbx(1'b1, 8'h00, 32'h30);
    wbx(1'b1, 8'h04, 32'h02);
    wbx(1'b1, 8'h10, 32'h08);
    push(3);
    pulse(1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    wbx(1'b0, 8'h14, 32'h0);
    chk("pointers", 32'h800, rdVal & 32'hee0);
    wbx(1'b0, 8'h0c, 32'h0);
    chk("status", 32'h8, rdVal);
    chk("irq clear", 32'h0, {31'h0, irq});
    wbx(1'b1, 8'h00, 32'h0);
    wbx(1'b1, 8'h04, 32'h0);
    push(1);
    pulse(1'b0);
    wbx(1'b0, 8'h14, 32'h0);
    chk("pointer kept", 32'h820, rdVal & 32'hee0);
    wbx(1'b0, 8'h0c, 32'h0);
    chk("no resync", 32'h0, rdVal);
    $display("t_sync done");
  endtask
  task automatic t_data;
    int seen;
    transmitGate <= 1'b1;
    watch(40, seen);
    chk("valid with gate", 32'h1, {31'h0, seen > 0});
    transmitGate <= 1'b0;
    push(2);
    watch(20, seen);
    chk("valid gate low", 32'h0, seen);
    $display("t_data done");
  endtask
  task automatic t_loss;
    wbx(1'b0, 8'h0c, 32'h0);
    clkRun <= 1'b0;
    ticks(20);
    chk("irq masked", 32'h0, {31'h0, irq});
    wbx(1'b0, 8'h0c, 32'h0);
    chk("clock loss", 32'h6, rdVal & 32'h6);
    clkRun <= 1'b1;
    ticks(4);
    $display("t_loss done");
  endtask
  task automatic t_strobe;
    reset_n <= 1'b0;
    ticks(6);
    reset_n <= 1'b1;
    ticks(1);
    wbx(1'b1, 8'h00, 32'h10);
    wbx(1'b1, 8'h08, 32'h02);
    pulse(1'b0);
    wbx(1'b0, 8'h14, 32'h0);
    chk("frame ignored", 32'h0, rdVal & 32'he00);
    pulse(1'b1);
    wbx(1'b0, 8'h14, 32'h0);
    chk("strobe sync", 32'h800, rdVal & 32'he00);
    $display("t_strobe done");
  endtask

  task summarize;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    transmitGate = 1'b0;
    sampleIn = 16'h0;
    sampleInValid = 1'b0;
    clkRun = 1'b1;
    frameReq = 1'b0;
    strobeReq = 1'b0;
    ticks(6);
    reset_n <= 1'b1;
    ticks(1);
    t_regs();
    t_sync();
    t_data();
    t_loss();
    t_strobe();
    summarize();
  end
endmodule
